// >>> rtl/pcu_pin_check_unit.v
// personal-code verify, change and disable command unit with apb registers
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "pcu_consts.vh"

module pcu_pin_check_unit (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg         secEnvRevalidate,
  output reg         cmdDone
);

  // register map (byte offsets)
  //   000 control, write only: bit0 start, bit1 clear data, bit2 new session
  //   004 header: [7:0] p2, [15:8] p1, [23:16] lc, [25:24] operation
  //   008 data, write only: each word shifts in, first code byte in bits 31:24
  //   00c status, read only: bit0 verified, bit4 busy, [6:5] tries, bit7 blocked,
  //       bit8 disabled, all but busy for the reference in p2
  //   010 status word of the last command
  //   014 access probe: [4:0] first reference, [9:5] second, bit10 two-reference
  //       file; bit11 reads back whether access is granted
  //   018 qualifier probe: [4:0] key select; [15:8] read back its usage qualifier
  //   status words: 9000 done, 63cx tries left, 6983 blocked, 6985 disabled,
  //   6b00 bad p1 or p2, 6700 bad length, 6a86 bad disable p1
  // an 8-byte code is followed by two filler words so that the compared value
  // always sits in the upper half of the buffer

  // two bits hold 0 to 3 tries; zero means blocked, so blocking needs no flag
  // of its own and persists across sessions just like the counter
  // per-reference state; the counter and flags model the persistent store
  reg [63:0] refValue   [0:`PCU_NREF-1];
  reg [1:0]  triesLeft  [0:`PCU_NREF-1];
  reg        refDisabled[0:`PCU_NREF-1];
  reg        refVerified[0:`PCU_NREF-1];
  reg [7:0]  keyQual    [0:`PCU_NREF-1];
  reg [4:0]  replKey    [0:`PCU_NREF-1];
  reg        replUsed   [0:`PCU_NREF-1];

  reg [1:0]   opCode_r;
  reg [7:0]   p1_r;
  reg [7:0]   p2_r;
  reg [7:0]   lc_r;
  reg [127:0] dataBuf_r;
  reg [15:0]  sw_r;
  reg         busy_r;
  reg [4:0]   accRef_r;
  reg [4:0]   accRef2_r;
  reg         accMulti_r;
  reg [4:0]   qualSel_r;
  integer     i;

  wire wrEn = psel & penable & pwrite;
  wire rdEn = psel & ~penable & ~pwrite;
  // a start request while busy is dropped; a command takes exactly one cycle
  wire goReq = wrEn && (paddr == `PCU_OFS_CTRL) && pwdata[`PCU_CTRL_GO] && !busy_r;

  wire [4:0]  refNum   = p2_r[4:0];
  wire [63:0] firstVal = dataBuf_r[127:64];
  wire [63:0] secondVal = dataBuf_r[63:0];
  wire        isBlocked = (triesLeft[refNum] == 2'h0);
  wire        match     = (firstVal == refValue[refNum]);
  wire [1:0]  triesDec  = triesLeft[refNum] - 2'h1;

  // header decode shared by the command paths
  wire        p2Bad      = (p2_r == 8'h00) || (p2_r[6:5] != 2'b00) ||
                           (p2_r[4:0] == 5'h00);
  wire        p1Zero     = (p1_r == 8'h00);
  wire        replReq    = p1_r[7];
  wire [4:0]  replNum    = p1_r[4:0];
  // disable p1: 00 plain, 01 reserved, top bit set with a nonzero key number
  wire        disP1Bad   = replReq ? (p1_r[6:5] != 2'b00 || replNum == 5'h00) : !p1Zero;
  // the query answer also serves the blocked case, as tries then read zero
  wire [15:0] swTriesNow = {`PCU_SW_TRIES, 2'b00, triesLeft[refNum]};

  // access condition for a guarded file
  function accOk;
    input [4:0] r;
    begin
      // a replacement key takes over the guard of the disabled code, in a single-reference file only
      if (replUsed[r])
        accOk = refVerified[replKey[r]] && triesLeft[replKey[r]] != 2'h0;
      else
        accOk = refDisabled[r] || (refVerified[r] && triesLeft[r] != 2'h0);
    end
  endfunction

  wire accessGranted = accMulti_r ?
    ((refDisabled[accRef_r] || refDisabled[accRef2_r]) ? 1'b1 :
     (accOk(accRef_r) || accOk(accRef2_r))) :
    accOk(accRef_r);

  assign pready  = 1'b1;
  // an erroring access has no effect: no listed offset matches it
  assign pslverr = psel & penable & (paddr[1:0] != 2'b00 || paddr > `PCU_OFS_QUAL);

  // read-back words, one per readable register except the status word at 010
  wire [31:0] hdrWord    = {6'h0, opCode_r, lc_r, p1_r, p2_r};
  wire [31:0] statusWord = {23'h0, refDisabled[refNum], isBlocked, triesLeft[refNum],
                            busy_r, 3'h0, refVerified[refNum]};
  wire [31:0] accessWord = {20'h0, accessGranted, accMulti_r, accRef2_r, accRef_r};
  wire [31:0] qualWord   = {16'h0, keyQual[qualSel_r], 3'h0, qualSel_r};
  reg  [31:0] rdMux;

  // unmapped offsets read zero
  always @* begin
    rdMux = 32'h0;
    case (paddr)
      `PCU_OFS_HDR:    rdMux = hdrWord;
      `PCU_OFS_STATUS: rdMux = statusWord;
      `PCU_OFS_SW:     rdMux = {16'h0, sw_r};
      `PCU_OFS_ACCESS: rdMux = accessWord;
      `PCU_OFS_QUAL:   rdMux = qualWord;
      default:         rdMux = 32'h0;
    endcase
  end

  // read data is captured in the setup cycle and stands through the access
  // phase; it drops back to zero at the access edge so the idle bus reads zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      prdata <= 32'h0;
    else if (rdEn)
      prdata <= rdMux;
    else if (psel && penable)
      prdata <= 32'h0;
  end

  // revalidation after disable
  // mirrors the disable path below so the pulse comes with the done pulse
  wire execDisableOk = busy_r && !p2Bad && (opCode_r == `PCU_OP_DISABLE) && !disP1Bad &&
                       (lc_r == `PCU_LC_ONE) && !isBlocked && !refDisabled[refNum] &&
                       match;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cmdDone          <= 1'b0;
      secEnvRevalidate <= 1'b0;
    end else begin
      cmdDone          <= busy_r;
      secEnvRevalidate <= execDisableOk;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      opCode_r         <= 2'h0;
      p1_r             <= 8'h00;
      p2_r             <= 8'h00;
      lc_r             <= 8'h00;
      dataBuf_r        <= 128'h0;
      sw_r             <= `PCU_SW_OK;
      busy_r           <= 1'b0;
      accRef_r         <= 5'h01;
      accRef2_r        <= 5'h01;
      accMulti_r       <= 1'b0;
      qualSel_r        <= 5'h00;
      // reset stands for card personalisation: default codes are zero
      for (i = 0; i < `PCU_NREF; i = i + 1) begin
        refValue[i]    <= 64'h0;
        triesLeft[i]   <= `PCU_TRIES_INIT;
        refDisabled[i] <= 1'b0;
        refVerified[i] <= 1'b0;
        keyQual[i]     <= `PCU_QUAL_NOUSE;
        replKey[i]     <= 5'h00;
        replUsed[i]    <= 1'b0;
      end
    end else begin
      // writes are refused while a command executes so that its header and
      // data cannot change under the comparison
      if (wrEn && !busy_r) begin
        case (paddr)
          `PCU_OFS_HDR: begin
            p2_r     <= pwdata[7:0];
            p1_r     <= pwdata[15:8];
            lc_r     <= pwdata[23:16];
            opCode_r <= pwdata[25:24];
          end
          // data bytes shift in one word at a time, first byte first
          `PCU_OFS_DATA: dataBuf_r <= {dataBuf_r[95:0], pwdata};
          `PCU_OFS_ACCESS: begin
            accRef_r   <= pwdata[4:0];
            accRef2_r  <= pwdata[9:5];
            accMulti_r <= pwdata[10];
          end
          `PCU_OFS_QUAL: qualSel_r <= pwdata[4:0];
          `PCU_OFS_CTRL: begin
            if (pwdata[`PCU_CTRL_CLRDAT])
              dataBuf_r <= 128'h0;
            // new session drops verification, keeps counters
            if (pwdata[`PCU_CTRL_SESS])
              for (i = 0; i < `PCU_NREF; i = i + 1)
                refVerified[i] <= 1'b0;
          end
          default: ;
        endcase
      end
      if (goReq)
        busy_r <= 1'b1;
      // counters and flags change here, one cycle after a start; a new session also clears verification
      if (busy_r) begin
        busy_r <= 1'b0;
        if (p2Bad)
          sw_r <= `PCU_SW_BADP12;
        else begin
          case (opCode_r)
            `PCU_OP_VERIFY: begin
              if (p1_r != 8'h00)
                sw_r <= `PCU_SW_BADP12;
              else if (lc_r == `PCU_LC_NONE)
                sw_r <= swTriesNow;
              else if (lc_r != `PCU_LC_ONE)
                sw_r <= `PCU_SW_BADLEN;
              else if (isBlocked)
                sw_r <= `PCU_SW_BLOCKED;
              else if (refDisabled[refNum])
                sw_r <= `PCU_SW_NOTALLOW;
              else if (match) begin
                triesLeft[refNum]   <= `PCU_TRIES_INIT;
                refVerified[refNum] <= 1'b1;
                sw_r <= `PCU_SW_OK;
              end else begin
                triesLeft[refNum]   <= triesDec;
                refVerified[refNum] <= 1'b0;
                sw_r <= {`PCU_SW_TRIES, 2'b00, triesDec};
              end
            end
            `PCU_OP_CHANGE: begin
              if (p1_r != 8'h00)
                sw_r <= `PCU_SW_BADP12;
              else if (lc_r != `PCU_LC_TWO)
                sw_r <= `PCU_SW_BADLEN;
              else if (isBlocked)
                sw_r <= `PCU_SW_BLOCKED;
              else if (refDisabled[refNum])
                sw_r <= `PCU_SW_NOTALLOW;
              else if (match) begin
                triesLeft[refNum] <= `PCU_TRIES_INIT;
                refValue[refNum]  <= secondVal;
                sw_r <= `PCU_SW_OK;
              end else begin
                triesLeft[refNum]   <= triesDec;
                refVerified[refNum] <= 1'b0;
                sw_r <= {`PCU_SW_TRIES, 2'b00, triesDec};
              end
            end
            `PCU_OP_DISABLE: begin
              if (disP1Bad)
                sw_r <= `PCU_SW_BADP1;
              else if (lc_r != `PCU_LC_ONE)
                sw_r <= `PCU_SW_BADLEN;
              else if (isBlocked)
                sw_r <= `PCU_SW_BLOCKED;
              else if (refDisabled[refNum])
                sw_r <= `PCU_SW_NOTALLOW;
              else if (match) begin
                triesLeft[refNum]   <= `PCU_TRIES_INIT;
                refDisabled[refNum] <= 1'b1;
                sw_r <= `PCU_SW_OK;
                if (p1_r[7]) begin
                  keyQual[p1_r[4:0]] <= `PCU_QUAL_USE;
                  replKey[refNum]    <= p1_r[4:0];
                  replUsed[refNum]   <= 1'b1;
                end
              end else begin
                triesLeft[refNum] <= triesDec;
                sw_r <= {`PCU_SW_TRIES, 2'b00, triesDec};
              end
            end
            default: begin
              // release path: data is new code only; the release code itself
              // is checked by logic outside this unit
              if (lc_r != `PCU_LC_ONE)
                sw_r <= `PCU_SW_BADLEN;
              else begin
                triesLeft[refNum]   <= `PCU_TRIES_INIT;
                refValue[refNum]    <= firstVal;
                refDisabled[refNum] <= 1'b0;
                refVerified[refNum] <= 1'b1;
                if (replUsed[refNum])
                  keyQual[replKey[refNum]] <= `PCU_QUAL_NOUSE;
                replUsed[refNum] <= 1'b0;
                sw_r <= `PCU_SW_OK;
              end
            end
          endcase
        end
      end
    end
  end

endmodule // pcu_pin_check_unit

// >>> rtl/pcu_consts.vh
// constants for the personal-code command unit
`ifndef PCU_CONSTS_VH
`define PCU_CONSTS_VH
`define PCU_OFS_CTRL     12'h000
`define PCU_OFS_HDR      12'h004
`define PCU_OFS_DATA     12'h008
`define PCU_OFS_STATUS   12'h00c
`define PCU_OFS_SW       12'h010
`define PCU_OFS_ACCESS   12'h014
`define PCU_OFS_QUAL     12'h018
`define PCU_CTRL_GO      0
`define PCU_CTRL_CLRDAT  1
`define PCU_CTRL_SESS    2
`define PCU_OP_VERIFY    2'h0
`define PCU_OP_CHANGE    2'h1
`define PCU_OP_DISABLE   2'h2
`define PCU_OP_RELEASE   2'h3
`define PCU_TRIES_INIT   2'h3
`define PCU_LC_NONE      8'h00
`define PCU_LC_ONE       8'h08
`define PCU_LC_TWO       8'h10
`define PCU_SW_OK        16'h9000
`define PCU_SW_TRIES     12'h63c
`define PCU_SW_BLOCKED   16'h6983
`define PCU_SW_BADP12    16'h6b00
`define PCU_SW_BADLEN    16'h6700
`define PCU_SW_NOTALLOW  16'h6985
`define PCU_SW_BADP1     16'h6a86
`define PCU_QUAL_USE     8'h08
`define PCU_QUAL_NOUSE   8'h00
`define PCU_NREF         32
`endif

// >>> tb/pcu_pin_check_chk.sv
// port-level assertions for the personal-code command unit
`timescale 1ns/100ps
module pcu_pin_check_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        secEnvRevalidate,
  input wire        cmdDone
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc = psel && penable;
  wire badAddr = (paddr[1:0] != 2'h0) || (paddr > 12'h018);
  wire goWr = acc && pwrite && (paddr == 12'h000) && pwdata[0];
  sequence s_go;
    goWr;
  endsequence
  sequence s_done;
    ##2 cmdDone ##1 !cmdDone;
  endsequence
  a_go_done: assert property (s_go |-> s_done)
    else $error("command did not finish in two cycles");
  a_done_cause: assert property ($rose(cmdDone) |-> $past(goWr, 2))
    else $error("done pulse without a start");
  a_reval_cause: assert property (secEnvRevalidate |-> $past(goWr, 2))
    else $error("revalidation without a command");
  a_reval_pulse: assert property (secEnvRevalidate |=> !secEnvRevalidate)
    else $error("revalidation pulse too long");
  a_zero_wait: assert property (acc |-> pready)
    else $error("wait state inserted");
  a_bad_addr: assert property (acc && badAddr |-> pslverr)
    else $error("bad address not refused");
  a_good_addr: assert property (acc && !badAddr |-> !pslverr)
    else $error("good address refused");
  a_rdata_idle: assert property (!psel |-> prdata == 32'h0)
    else $error("read data not zero while idle");
endmodule // pcu_pin_check_chk

// >>> tb/pcu_term_model.sv
// terminal model: apb master issuing command headers and code data
`timescale 1ns/100ps
`include "pcu_consts.vh"
module pcu_term_model (
  input  wire        clk,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  input  wire [31:0] prdata,
  input  wire        pready,
  input  wire        pslverr,
  input  wire        cmdDone
);
  integer k;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q, output e);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released data lines show the inverse, not a stale copy
      pwdata <= ~d;
    end
  endtask
  // header then code words, old value first
  task sendCmd(input [1:0] op, input [7:0] p1, p2, lc, input [63:0] a, b,
               output [31:0] sw);
    reg [31:0] q;
    reg        e;
    begin
      xfer(1'b1, `PCU_OFS_HDR, {6'h0, op, lc, p1, p2}, q, e);
      xfer(1'b1, `PCU_OFS_CTRL, 32'h2, q, e);
      xfer(1'b1, `PCU_OFS_DATA, a[63:32], q, e);
      xfer(1'b1, `PCU_OFS_DATA, a[31:0], q, e);
      xfer(1'b1, `PCU_OFS_DATA, b[63:32], q, e);
      xfer(1'b1, `PCU_OFS_DATA, b[31:0], q, e);
      xfer(1'b1, `PCU_OFS_CTRL, 32'h1, q, e);
      for (k = 0; k < 20 && cmdDone !== 1'b1; k = k + 1) @(negedge clk);
      xfer(1'b0, `PCU_OFS_SW, 32'h0, sw, e);
      // a missing done pulse must show as a mismatch, never as a stale word
      if (k >= 20) sw = 32'hffffffff;
    end
  endtask
endmodule // pcu_term_model

// >>> tb/pcu_pin_check_unit_test.sv
// self-checking bench for the personal-code command unit
`timescale 1ns/100ps
`include "pcu_consts.vh"
module pcu_pin_check_unit_test;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  wire psel, penable, pwrite, pready, pslverr, secEnvRevalidate, cmdDone;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  integer fails = 0, n_tests = 0, seed = 32'h056d, i;
  integer nReval = 0, rv;
  reg [63:0] code [0:31];
  reg [1:0]  tr [0:31];
  reg        bl [0:31], ds [0:31], e;
  reg [31:0] q, exp;
  reg [1:0]  op;
  reg [4:0]  r;
  reg [7:0]  lc;
  reg [63:0] a, b;
  pcu_pin_check_unit dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .secEnvRevalidate(secEnvRevalidate), .cmdDone(cmdDone));
  pcu_term_model term (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmdDone(cmdDone));
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) if (secEnvRevalidate) nReval <= nReval + 1;
  task chk(input [31:0] seen, input [31:0] want);
    begin
      n_tests = n_tests + 1;
      if (seen !== want) begin
        fails = fails + 1;
        $display("Error at %0t: seen %h expected %h", $time, seen, want);
      end
    end
  endtask
  // expected status word; updates the bench copy of the code state
  function [15:0] mdl(input [1:0] o, input [4:0] n, input [7:0] l, input [63:0] x, y);
    begin
      if (o == `PCU_OP_RELEASE) begin
        code[n] = x;
        tr[n] = 2'h3;
        bl[n] = 1'b0;
        ds[n] = 1'b0;
        mdl = `PCU_SW_OK;
      end else if (o == `PCU_OP_VERIFY && l == `PCU_LC_NONE) mdl = {12'h63c, 2'h0, tr[n]};
      else if (bl[n]) mdl = `PCU_SW_BLOCKED;
      else if (ds[n]) mdl = `PCU_SW_NOTALLOW;
      else if (x == code[n]) begin
        tr[n] = 2'h3;
        if (o == `PCU_OP_CHANGE) code[n] = y;
        if (o == `PCU_OP_DISABLE) ds[n] = 1'b1;
        mdl = `PCU_SW_OK;
      end else begin
        tr[n] = tr[n] - 2'h1;
        bl[n] = (tr[n] == 2'h0);
        mdl = {12'h63c, 2'h0, tr[n]};
      end
    end
  endfunction
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial begin
    #100000;
    fails = fails + 1;
    complete_run;
  end
  initial begin
    for (i = 0; i < 32; i = i + 1) begin
      code[i] = 64'h0;
      tr[i] = 2'h3;
      bl[i] = 1'b0;
      ds[i] = 1'b0;
    end
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    term.xfer(1'b0, `PCU_OFS_SW, 32'h0, q, e);
    chk(q, 32'h9000);
    term.xfer(1'b0, 12'h01c, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    term.sendCmd(2'h0, 8'h00, 8'h00, 8'h08, 64'h0, 64'h0, q);
    chk(q, `PCU_SW_BADP12);
    term.sendCmd(2'h0, 8'h00, 8'h41, 8'h08, 64'h0, 64'h0, q);
    chk(q, `PCU_SW_BADP12);
    term.sendCmd(2'h0, 8'h00, 8'h80, 8'h08, 64'h0, 64'h0, q);
    chk(q, `PCU_SW_BADP12);
    term.sendCmd(2'h0, 8'h00, 8'h01, 8'h10, 64'h0, 64'h0, q);
    chk(q, `PCU_SW_BADLEN);
    term.sendCmd(2'h2, 8'h01, 8'h01, 8'h08, 64'h0, 64'h0, q);
    chk(q, `PCU_SW_BADP1);
    for (i = 0; i < 80; i = i + 1) begin
      op = $random(seed);
      if (op == 2'h3 && $random(seed) % 2) op = 2'h0;
      r = 5'h1 + {$random(seed)} % 3;
      a = ({$random(seed)} % 2) ? code[r] : {$random(seed), $random(seed)};
      b = {$random(seed), $random(seed)};
      lc = (op == 2'h1) ? 8'h10 : ((op == 2'h0 && {$random(seed)} % 3 == 0) ? 8'h0 : 8'h8);
      exp = mdl(op, r, lc, a, b);
      term.sendCmd(op, 8'h00, {3'h0, r}, lc, a, b, q);
      chk(q, exp);
      term.xfer(1'b0, `PCU_OFS_STATUS, 32'h0, q, e);
      chk(q & 32'h1e0, {23'h0, ds[r], bl[r], tr[r], 5'h0});
      // a new session must keep the counters
      if ({$random(seed)} % 8 == 0) term.xfer(1'b1, `PCU_OFS_CTRL, 32'h4, q, e);
    end
    // directed access checks on references the random part never touches
    term.xfer(1'b1, `PCU_OFS_ACCESS, 32'h5, q, e);
    term.xfer(1'b0, `PCU_OFS_ACCESS, 32'h0, q, e);
    chk(q, 32'h5);
    term.sendCmd(2'h0, 8'h00, 8'h05, 8'h08, 64'h0, 64'h0, q);
    chk(q, 32'h9000);
    term.xfer(1'b0, `PCU_OFS_ACCESS, 32'h0, q, e);
    chk(q, 32'h805);
    term.xfer(1'b1, `PCU_OFS_CTRL, 32'h4, q, e);
    term.xfer(1'b0, `PCU_OFS_ACCESS, 32'h0, q, e);
    chk(q, 32'h5);
    rv = nReval;
    term.sendCmd(2'h2, 8'h86, 8'h05, 8'h08, 64'h0, 64'h0, q);
    chk(q, 32'h9000);
    chk(nReval - rv, 32'h1);
    term.xfer(1'b1, `PCU_OFS_QUAL, 32'h6, q, e);
    term.xfer(1'b0, `PCU_OFS_QUAL, 32'h0, q, e);
    chk(q, 32'h0806);
    term.xfer(1'b0, `PCU_OFS_ACCESS, 32'h0, q, e);
    chk(q, 32'h5);
    term.sendCmd(2'h0, 8'h00, 8'h06, 8'h08, 64'h0, 64'h0, q);
    chk(q, 32'h9000);
    term.xfer(1'b0, `PCU_OFS_ACCESS, 32'h0, q, e);
    chk(q, 32'h805);
    term.xfer(1'b1, `PCU_OFS_ACCESS, 32'h4a7, q, e);
    term.xfer(1'b0, `PCU_OFS_ACCESS, 32'h0, q, e);
    chk(q, 32'hca7);
    term.xfer(1'b1, `PCU_OFS_ACCESS, 32'h507, q, e);
    term.xfer(1'b0, `PCU_OFS_ACCESS, 32'h0, q, e);
    chk(q, 32'h507);
    complete_run;
  end
endmodule // pcu_pin_check_unit_test
bind pcu_pin_check_unit pcu_pin_check_chk chk (.clk(clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .secEnvRevalidate(secEnvRevalidate),
  .cmdDone(cmdDone));
